// ===== inc/sbxe_pkg.sv
package sbxe_pkg;

  // ********************
  // opcode formats
  // ********************
  localparam logic [4:0] SBXE_OP_SUB_REG_HI = 5'h13;
  localparam logic [7:0] SBXE_OP_SUB_DIR = 8'h95;
  localparam logic [7:0] SBXE_OP_XCH_DIR = 8'hC5;
  localparam int SBXE_REG_SEL_W = 3;
  localparam int SBXE_REG_HI_LSB = 3;

  // ********************
  // status word bit positions
  // ********************
  localparam int SBXE_PSW_CY = 7;
  localparam int SBXE_PSW_AC = 6;
  localparam int SBXE_PSW_OV = 2;
  localparam int SBXE_PSW_P = 0;
  localparam logic [7:0] SBXE_ACC_RST = 8'h00;
  localparam logic [7:0] SBXE_PSW_RST = 8'h00;
  localparam logic [7:0] SBXE_BYTE_ZERO = 8'h00;
  localparam logic [4:0] SBXE_BANK_BASE_RST = 5'h00;

  typedef enum logic [1:0] {
    SBXE_IDLE = 2'b00,
    SBXE_FETCH_ADDR = 2'b01,
    SBXE_EXEC = 2'b10
  } sbxe_state_e;

  typedef enum logic [1:0] {
    SBXE_K_NONE = 2'b00,
    SBXE_K_SUB_REG = 2'b01,
    SBXE_K_SUB_DIR = 2'b10,
    SBXE_K_XCH_DIR = 2'b11
  } sbxe_kind_e;

  // memory write request toward internal data memory
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } sbxe_mem_wr_s;

endpackage : sbxe_pkg

// ===== verilog/sbxe_alu.sv
`timescale 1ns/1ps
module sbxe_alu
  import sbxe_pkg::*;
(
  input wire logic [7:0] acc,
  input wire logic [7:0] opnd,
  input wire logic cy_in,
  output logic [7:0] diff,
  output logic cy_out,
  output logic ac_out,
  output logic ov_out
);
  logic [8:0] full;
  logic [4:0] low;

  // 9-bit subtraction, top bit is the borrow out of bit 7
  assign full = {1'b0, acc} - {1'b0, opnd} - {8'h00, cy_in};
  assign low = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cy_in};
  assign diff = full[7:0];
  assign cy_out = full[8];
  assign ac_out = low[4];
  // signed overflow: operand signs differ and result sign differs from acc
  assign ov_out = (acc[7] ^ opnd[7]) & (acc[7] ^ full[7]);
endmodule : sbxe_alu

// ===== verilog/sbxe_exec.sv
`timescale 1ns/1ps
module sbxe_exec
  import sbxe_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic OP_VALID,
  input wire logic [7:0] OP_BYTE,
  input wire logic [4:0] BANK_BASE,
  input wire logic [7:0] MEM_RDATA,
  input wire logic [7:0] PSW_IN,
  output logic OP_READY,
  output logic [7:0] MEM_RADDR,
  output sbxe_mem_wr_s MEM_WR,
  output logic [7:0] ACC,
  output logic [7:0] PROGRAM_STATUS_WORD,
  output logic DONE,
  output logic ILLEGAL
);

  // ********************
  // state and decode
  // ********************
  sbxe_state_e state_q, state_d;
  sbxe_kind_e kind_q, kind_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] psw_q, psw_d;
  logic [7:0] raddr_q, raddr_d;
  sbxe_mem_wr_s wr_q, wr_d;
  logic done_q, done_d;
  logic ill_q, ill_d;
  logic ready_q, ready_d;
  logic psw_seen_q;

  wire is_sub_reg = OP_BYTE[7:SBXE_REG_HI_LSB] == SBXE_OP_SUB_REG_HI;
  wire is_sub_dir = OP_BYTE == SBXE_OP_SUB_DIR;
  wire is_xch_dir = OP_BYTE == SBXE_OP_XCH_DIR;
  wire [SBXE_REG_SEL_W-1:0] reg_sel = OP_BYTE[SBXE_REG_SEL_W-1:0];
  // working register address: bank base in bits 7:3, register number in bits 2:0
  wire [7:0] reg_addr = {BANK_BASE, reg_sel};
  // a byte is accepted only while ready is high; during execute the memory port is busy
  wire take = OP_VALID && ready_q;
  // both direct forms need a second byte for the address
  wire is_dir_form = is_sub_dir || is_xch_dir;

  function automatic logic even_par(input logic [7:0] v);
    even_par = ^v;
  endfunction : even_par

  // ********************
  // arithmetic
  // ********************
  logic [7:0] diff;
  logic cy_n, ac_n, ov_n;
  // carry seen by the subtract: core status word, unless we already own a newer copy
  wire cy_cur = psw_seen_q ? psw_q[SBXE_PSW_CY] : PSW_IN[SBXE_PSW_CY];
  wire [7:0] psw_base = psw_seen_q ? psw_q : PSW_IN;

  sbxe_alu u_alu (
    .acc(acc_q),
    .opnd(MEM_RDATA),
    .cy_in(cy_cur),
    .diff(diff),
    .cy_out(cy_n),
    .ac_out(ac_n),
    .ov_out(ov_n)
  );

  // ********************
  // execute-cycle results
  // ********************
  // exchange: the memory byte becomes the accumulator and only parity follows it
  wire [7:0] xch_acc = MEM_RDATA;
  wire xch_par = even_par(xch_acc);
  // subtract: the difference and four freshly computed flags
  wire sub_par = even_par(diff);
  wire exec_is_xch = kind_q == SBXE_K_XCH_DIR;
  // only the exchange writes memory, so a subtract leaves its register operand alone
  wire exec_we = exec_is_xch;
  logic [7:0] psw_xch;
  logic [7:0] psw_sub;
  logic [7:0] exec_acc;
  logic [7:0] exec_psw;

  // bits the exchange does not own are passed through from the base copy
  always_comb begin
    psw_xch = psw_base;
    psw_xch[SBXE_PSW_P] = xch_par;
  end

  always_comb begin
    psw_sub = psw_base;
    psw_sub[SBXE_PSW_CY] = cy_n;
    psw_sub[SBXE_PSW_AC] = ac_n;
    psw_sub[SBXE_PSW_OV] = ov_n;
    psw_sub[SBXE_PSW_P] = sub_par;
  end

  assign exec_acc = exec_is_xch ? xch_acc : diff;
  assign exec_psw = exec_is_xch ? psw_xch : psw_sub;

  // ********************
  // sequencing
  // ********************
  // operand is read from memory in EXEC; registers sit in the same memory, so one path serves both forms
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    acc_d = acc_q;
    psw_d = psw_q;
    raddr_d = raddr_q;
    wr_d = '{we: 1'b0, addr: raddr_q, data: SBXE_BYTE_ZERO};
    done_d = 1'b0;
    ill_d = 1'b0;
    ready_d = ready_q;
    unique case (state_q)
      SBXE_IDLE: begin
        if (take) begin
          if (is_sub_reg) begin
            kind_d = SBXE_K_SUB_REG;
            raddr_d = reg_addr;
            state_d = SBXE_EXEC;
            ready_d = 1'b0;
          end else if (is_dir_form) begin
            kind_d = is_sub_dir ? SBXE_K_SUB_DIR : SBXE_K_XCH_DIR;
            // ready stays high so the address byte may follow back to back
            state_d = SBXE_FETCH_ADDR;
          end else begin
            // any other first byte is flagged and dropped
            ill_d = 1'b1;
          end
        end
      end
      SBXE_FETCH_ADDR: begin
        if (take) begin
          raddr_d = OP_BYTE;
          state_d = SBXE_EXEC;
          ready_d = 1'b0;
        end
      end
      SBXE_EXEC: begin
        acc_d = exec_acc;
        psw_d = exec_psw;
        wr_d = '{we: exec_we, addr: raddr_q, data: acc_q};
        done_d = 1'b1;
        // cleared so a stale form never leaks into the next byte
        kind_d = SBXE_K_NONE;
        state_d = SBXE_IDLE;
        ready_d = 1'b1;
      end
      default: begin
        state_d = SBXE_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // ********************
  // registers
  // ********************
  // sequencing state; ready leaves reset high so a byte can be taken at once
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= SBXE_IDLE;
      kind_q <= SBXE_K_NONE;
      raddr_q <= SBXE_BYTE_ZERO;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      raddr_q <= raddr_d;
      ready_q <= ready_d;
    end
  end

  // architectural results
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      acc_q <= SBXE_ACC_RST;
      psw_q <= SBXE_PSW_RST;
    end else begin
      acc_q <= acc_d;
      psw_q <= psw_d;
    end
  end

  // after a first completion our own flag copy is the newest one
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      psw_seen_q <= 1'b0;
    end else if (done_d) begin
      psw_seen_q <= 1'b1;
    end
  end

  // one-cycle pulses
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_q <= '0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      done_q <= done_d;
      ill_q <= ill_d;
    end
  end

  assign OP_READY = ready_q;
  assign MEM_RADDR = raddr_q;
  assign MEM_WR = wr_q;
  assign ACC = acc_q;
  assign PROGRAM_STATUS_WORD = psw_q;
  assign DONE = done_q;
  assign ILLEGAL = ill_q;

endmodule : sbxe_exec

// ===== bench/sbxe_exec_assertions.sv
`timescale 1ns/1ps
module sbxe_exec_chk
  import sbxe_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic OP_VALID,
  input wire logic OP_READY,
  input wire logic DONE,
  input wire logic ILLEGAL,
  input wire logic [7:0] OP_BYTE,
  input wire logic [7:0] MEM_RADDR,
  input wire logic [7:0] MEM_RDATA,
  input wire logic [7:0] ACC,
  input wire logic [7:0] PROGRAM_STATUS_WORD,
  input wire sbxe_mem_wr_s MEM_WR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic dir_q, seen_q;
  wire tk = OP_VALID && OP_READY;
  wire dop = OP_BYTE == SBXE_OP_SUB_DIR || OP_BYTE == SBXE_OP_XCH_DIR;
  // flags before the first completion come from outside
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST) {dir_q, seen_q} <= 2'b00;
    else {dir_q, seen_q} <= {tk ? !dir_q && dop : dir_q, seen_q | DONE};
  sequence s_exe; !OP_READY ##1 DONE; endsequence
  property p_reg; tk && !dir_q && OP_BYTE[7:3] == SBXE_OP_SUB_REG_HI
    |=> MEM_RADDR[2:0] == $past(OP_BYTE[2:0]) ##1 DONE && !MEM_WR.we; endproperty
  property p_dir; tk && dir_q |=> MEM_RADDR == $past(OP_BYTE) ##0 s_exe; endproperty
  property p_swap; MEM_WR.we |-> MEM_WR.data == $past(ACC); endproperty
  property p_keep; MEM_WR.we && seen_q |-> (PROGRAM_STATUS_WORD & 8'hC4) == ($past(PROGRAM_STATUS_WORD) & 8'hC4); endproperty
  property p_par; DONE |-> PROGRAM_STATUS_WORD[SBXE_PSW_P] == ^ACC; endproperty
  property p_stand; !DONE |-> $stable(ACC) && $stable(PROGRAM_STATUS_WORD); endproperty
  property p_gap; !OP_READY |=> DONE; endproperty
  property p_wr; MEM_WR.we |-> DONE; endproperty
  property p_xacc; MEM_WR.we |-> ACC == $past(MEM_RDATA) && MEM_WR.addr == $past(MEM_RADDR); endproperty
  property p_diff; DONE && !MEM_WR.we && seen_q
    |-> ACC == $past(ACC) - $past(MEM_RDATA) - $past(PROGRAM_STATUS_WORD[SBXE_PSW_CY]); endproperty
  property p_ill; tk && !dir_q && OP_BYTE[7:3] != SBXE_OP_SUB_REG_HI && !dop
    |=> ILLEGAL && OP_READY; endproperty
  a_reg: assert property (p_reg) else $error("reg");
  a_dir: assert property (p_dir) else $error("dir");
  a_swap: assert property (p_swap) else $error("swap");
  a_keep: assert property (p_keep) else $error("keep");
  a_par: assert property (p_par) else $error("par");
  a_stand: assert property (p_stand) else $error("stand");
  a_gap: assert property (p_gap) else $error("gap");
  a_wr: assert property (p_wr) else $error("wr");
  a_xacc: assert property (p_xacc) else $error("xacc");
  a_diff: assert property (p_diff) else $error("diff");
  a_ill: assert property (p_ill) else $error("ill");
endmodule : sbxe_exec_chk
bind sbxe_exec sbxe_exec_chk chk (.CLK, .NRST, .OP_VALID, .OP_READY, .DONE, .ILLEGAL, .OP_BYTE, .MEM_RADDR,
  .MEM_RDATA, .ACC, .PROGRAM_STATUS_WORD, .MEM_WR);

// ===== bench/sbxe_exec_tb_top.sv
`timescale 1ns/1ps
module sbxe_exec_tb_top;
  import sbxe_pkg::*;
  logic CLK = 0, NRST = 0, OP_VALID = 0, OP_READY, DONE, ILLEGAL, cy_m = 1, ac_m = 0, ov_m = 0;
  logic [7:0] OP_BYTE = 8'h00, MEM_RADDR, ACC, PROGRAM_STATUS_WORD, acc_m = 8'h00, psw_in = 8'h80, mem [256];
  logic [4:0] BANK_BASE = 5'h03;
  sbxe_mem_wr_s MEM_WR;
  int n_mismatch = 0, samples_checked = 0;
  wire [7:0] MEM_RDATA = mem[MEM_RADDR];
  always #50 CLK = ~CLK;
  always @(posedge CLK) if (MEM_WR.we) mem[MEM_WR.addr] <= MEM_WR.data;
  sbxe_exec dut (.CLK, .NRST, .OP_VALID, .OP_BYTE, .BANK_BASE, .MEM_RDATA, .PSW_IN(psw_in), .OP_READY,
    .MEM_RADDR, .MEM_WR, .ACC, .PROGRAM_STATUS_WORD, .DONE, .ILLEGAL);
  task automatic cmp(string n, logic [7:0] s, logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic cmp_bit(string n, logic s, logic e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s exp %b got %b", n, e, s);
    end
  endtask : cmp_bit
  // reference subtract with borrow, flags from their definitions
  task automatic model_sub(logic [7:0] v);
    int s;
    s = int'($signed(acc_m)) - int'($signed(v)) - int'(cy_m);
    ac_m = {1'b0, acc_m[3:0]} < {1'b0, v[3:0]} + cy_m;
    ov_m = s < -128 || s > 127;
    {cy_m, acc_m} = {1'b0, acc_m} - v - cy_m;
  endtask : model_sub
  // opcode, then the address byte for the direct forms, one byte per cycle
  task automatic issue(logic [7:0] o, logic [7:0] ad, bit dir);
    @(negedge CLK);
    OP_VALID = 1'b1;
    OP_BYTE = o;
    if (dir) begin
      @(negedge CLK);
      OP_BYTE = ad;
    end
    @(negedge CLK);
    OP_VALID = 1'b0;
  endtask : issue
  // called in the execute cycle, returns one cycle after the done pulse
  task automatic finish_check(logic [7:0] ra);
    cmp("raddr", MEM_RADDR, ra);
    cmp_bit("ready", OP_READY, 1'b0);
    cmp_bit("done_early", DONE, 1'b0);
    @(negedge CLK);
    cmp_bit("done", DONE, 1'b1);
    cmp("acc", ACC, acc_m);
    cmp("psw", PROGRAM_STATUS_WORD & 8'hC5, {cy_m, ac_m, 3'b000, ov_m, 1'b0, ^acc_m});
    @(negedge CLK);
    cmp_bit("done_pulse", DONE, 1'b0);
  endtask : finish_check
  task automatic sub_reg_test(logic [2:0] r, logic [7:0] v);
    mem[{BANK_BASE, r}] = v;
    model_sub(v);
    issue({SBXE_OP_SUB_REG_HI, r}, 8'h00, 1'b0);
    finish_check({BANK_BASE, r});
    cmp("reg_kept", mem[{BANK_BASE, r}], v);
  endtask : sub_reg_test
  task automatic sub_dir_test(logic [7:0] ad, logic [7:0] v);
    mem[ad] = v;
    model_sub(v);
    issue(SBXE_OP_SUB_DIR, ad, 1'b1);
    finish_check(ad);
  endtask : sub_dir_test
  task automatic xch_dir_test(logic [7:0] ad, logic [7:0] v);
    logic [7:0] old;
    old = acc_m;
    mem[ad] = v;
    acc_m = v;
    issue(SBXE_OP_XCH_DIR, ad, 1'b1);
    finish_check(ad);
    cmp("mem_xch", mem[ad], old);
  endtask : xch_dir_test
  task automatic illegal_test(logic [7:0] o);
    @(negedge CLK);
    OP_VALID = 1'b1;
    OP_BYTE = o;
    @(negedge CLK);
    OP_VALID = 1'b0;
    cmp_bit("illegal", ILLEGAL, 1'b1);
    cmp_bit("ready_ill", OP_READY, 1'b1);
    @(negedge CLK);
    cmp_bit("illegal_pulse", ILLEGAL, 1'b0);
    cmp_bit("done_ill", DONE, 1'b0);
    cmp("acc_ill", ACC, acc_m);
  endtask : illegal_test
  // mid-run reset; carry must come from the core status word again afterwards
  task automatic reset_test;
    @(negedge CLK);
    NRST = 1'b0;
    psw_in = 8'h00;
    @(negedge CLK);
    cmp("acc_rst", ACC, SBXE_ACC_RST);
    cmp("psw_rst", PROGRAM_STATUS_WORD, SBXE_PSW_RST);
    cmp_bit("ready_rst", OP_READY, 1'b1);
    NRST = 1'b1;
    acc_m = SBXE_ACC_RST;
    cy_m = psw_in[SBXE_PSW_CY];
  endtask : reset_test
  task automatic summarize;
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(negedge CLK);
    NRST = 1;
    sub_reg_test(3'h7, 8'h58);
    xch_dir_test(8'h7A, 8'hBD);
    sub_dir_test(8'h7A, 8'hAB);
    illegal_test(8'h94);
    reset_test();
    BANK_BASE = 5'h02;
    sub_reg_test(3'h0, 8'h80);
    summarize();
  end
  // about six times the expected run
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
endmodule : sbxe_exec_tb_top
